// file: src/flash_range_pkg.sv
// constants for the flash self-programming range and protect block
package flash_range_pkg;
	localparam logic [15:0] BLOCK_NUMBER_COMPARE_ADDR = 16'hFFA6;
	localparam logic [15:0] END_ADDRESS_COMPARE_ADDR  = 16'hFFA7;
	localparam logic [15:0] PROGRAM_DATA_BUFFER_ADDR  = 16'hFFA8;
	localparam logic [15:0] PROTECT_BYTE_ADDR         = 16'h0081;
	localparam logic [15:0] FLASH_STATUS_ADDR         = 16'hFFA1;
	localparam logic [2:0]  STATUS_PROT_BIT           = 3'h2;
	localparam logic [2:0]  STATUS_VFY_BIT            = 3'h1;
	localparam logic [7:0]  COMPARE_RESET             = 8'h00;
	localparam logic [7:0]  BUFFER_RESET              = 8'h00;
	localparam logic [7:0]  PROTECT_FIXED_MASK        = 8'h83;
	localparam int          SELECT_LSB                = 2;
	localparam int          SELECT_MSB                = 6;
	localparam logic [2:0]  CMD_VERIFY                = 3'h1;
	localparam logic [2:0]  CMD_ERASE                 = 3'h3;
	localparam logic [2:0]  CMD_BLANK                 = 3'h4;
	localparam logic [2:0]  CMD_WRITE                 = 3'h5;
	localparam logic [4:0]  SELECT_NONE               = 5'h1F;
	localparam int          BLOCK_BITS                = 4;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_PULSE,
		ST_WAIT,
		ST_STEP,
		ST_DONE
	} seq_state_t;
endpackage

// file: src/flash_selfprog_range_protect.sv
// range compare, program data buffer and protect check for self-programming
// ============================================================
// Summary of operation
// - for verify and blank check, the sequencer stops its address walk at the compare register pair.
// - both compare registers reset to zero; bit or byte writes accepted.
// - eight-bit program data buffer, byte writes only, resets to zero.
// - protect byte at 0081 applies only in self-programming mode.
// - erase or write to a protected block does nothing.
// - protect byte bits 7,1,0 are ones; bits 6..2 form the select code.
// - four-block parts: 01110 protects 3-0, 01111 1-0, 11111 none.
// - eight-block parts: 01100..01111 protect 7-0, 5-0, 3-0, 1-0.
// - sixteen-block parts: 01000..01111 protect 15-0 down to 1-0.
// - command on a shielded block sets the protect error flag.
// - for verify and blank check, pointers count upward until equal to the compare registers or a check fails.
// - a failed verification sets the verify fail flag.
`timescale 1ns/100ps
module flash_selfprog_range_protect
	import flash_range_pkg::*;
#(
	parameter int NUM_BLOCKS = 16
)
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [15:0] bus_addr_i,
	input  wire logic        bus_wr_i,
	input  wire logic        bus_bit_i,
	input  wire logic [2:0]  bus_bit_sel_i,
	input  wire logic [7:0]  bus_wdata_i,
	output logic [7:0]       bus_rdata_o,
	input  wire logic        selfprog_mode_i,
	input  wire logic [7:0]  protect_byte_i,
	input  wire logic [2:0]  flash_command_reg_i,
	input  wire logic        start_i,
	input  wire logic [7:0]  block_number_pointer_i,
	input  wire logic [7:0]  low_address_pointer_i,
	output logic             pointer_inc_o,
	output logic             pointer_low_inc_o,
	output logic             flash_pulse_o,
	output logic [2:0]       flash_op_o,
	output logic [7:0]       program_data_o,
	input  wire logic        flash_ready_i,
	input  wire logic        flash_verify_ok_i,
	output logic             erase_write_protect_error_o,
	output logic             verify_fail_flag_o,
	output logic             busy_o,
	output logic             done_o
);
	import flash_range_pkg::*;

	typedef struct packed {
		logic [7:0] block_number_compare;
		logic [7:0] end_address_compare;
		logic [7:0] program_data_buffer;
		seq_state_t state;
		logic [2:0] op;
		logic       pulse;
		logic       inc;
		logic       low_inc;
		logic       prot_err;
		logic       vfy_err;
		logic       done;
		logic [7:0] rdata;
	} state_t;

	state_t     s_q;
	state_t     s_d;
	logic [4:0] select_code;
	logic       blk_protected;
	logic       code_prohibited;
	logic       at_end;
	logic       is_erase_write;
	logic       prot_set;
	logic       vfy_set;

	assign select_code = protect_byte_i[SELECT_MSB:SELECT_LSB];

	protect_decode #(
		.NUM_BLOCKS (NUM_BLOCKS)
	) u_decode (
		.select_i     (select_code),
		.block_i      (block_number_pointer_i[BLOCK_BITS-1:0]),
		.protected_o  (blk_protected),
		.prohibited_o (code_prohibited)
	);

	assign at_end = (block_number_pointer_i == s_q.block_number_compare)
		&& (low_address_pointer_i == s_q.end_address_compare);
	assign is_erase_write = (s_q.op == CMD_ERASE) || (s_q.op == CMD_WRITE);

	always_comb
	begin
		s_d         = s_q;
		s_d.pulse   = 1'b0;
		s_d.inc     = 1'b0;
		s_d.low_inc = 1'b0;
		s_d.done    = 1'b0;
		prot_set    = 1'b0;
		vfy_set     = 1'b0;
		// ============================================================
		// register writes
		if (bus_wr_i)
		begin
			if (bus_addr_i == BLOCK_NUMBER_COMPARE_ADDR)
			begin
				if (bus_bit_i)
					s_d.block_number_compare[bus_bit_sel_i] =
						bus_wdata_i[0];
				else
					s_d.block_number_compare = bus_wdata_i;
			end
			else if (bus_addr_i == END_ADDRESS_COMPARE_ADDR)
			begin
				if (bus_bit_i)
					s_d.end_address_compare[bus_bit_sel_i] =
						bus_wdata_i[0];
				else
					s_d.end_address_compare = bus_wdata_i;
			end
			else if (bus_addr_i == PROGRAM_DATA_BUFFER_ADDR && !bus_bit_i)
			begin
				s_d.program_data_buffer = bus_wdata_i;
			end
		end
		// ============================================================
		// register reads
		if (bus_addr_i == BLOCK_NUMBER_COMPARE_ADDR)
			s_d.rdata = s_q.block_number_compare;
		else if (bus_addr_i == END_ADDRESS_COMPARE_ADDR)
			s_d.rdata = s_q.end_address_compare;
		else if (bus_addr_i == PROGRAM_DATA_BUFFER_ADDR)
			s_d.rdata = s_q.program_data_buffer;
		else
			s_d.rdata = 8'h00;
		// ============================================================
		// sequencer
		case (s_q.state)
			ST_IDLE:
			begin
				if (start_i && selfprog_mode_i)
				begin
					s_d.op    = flash_command_reg_i;
					s_d.state = ST_CHECK;
				end
			end
			ST_CHECK:
			begin
				// protection only counts in self-programming mode
				if (selfprog_mode_i && (blk_protected || code_prohibited))
				begin
					prot_set  = 1'b1;
					s_d.state = ST_DONE;
				end
				else if (s_q.op == CMD_VERIFY || s_q.op == CMD_ERASE
					|| s_q.op == CMD_BLANK || s_q.op == CMD_WRITE)
				begin
					s_d.pulse = 1'b1;
					s_d.state = ST_WAIT;
				end
				else
				begin
					s_d.state = ST_DONE;
				end
			end
			ST_WAIT:
			begin
				if (flash_ready_i)
				begin
					if (!flash_verify_ok_i)
					begin
						vfy_set   = 1'b1;
						s_d.state = ST_DONE;
					end
					else if (at_end || is_erase_write)
						s_d.state = ST_DONE;
					else
						s_d.state = ST_STEP;
				end
			end
			ST_STEP:
			begin
				if (low_address_pointer_i == 8'hFF)
					s_d.inc = 1'b1;
				s_d.low_inc = 1'b1;
				s_d.state   = ST_PULSE;
			end
			ST_PULSE:
			begin
				s_d.pulse = 1'b1;
				s_d.state = ST_WAIT;
			end
			ST_DONE:
			begin
				s_d.done  = 1'b1;
				s_d.state = ST_IDLE;
			end
			default:
			begin
				s_d.state = ST_IDLE;
			end
		endcase
		// ============================================================
		// status flags: cleared by writing zero, hardware set wins
		if (bus_wr_i && bus_addr_i == FLASH_STATUS_ADDR)
		begin
			if (bus_bit_i)
			begin
				if (bus_bit_sel_i == STATUS_PROT_BIT && !bus_wdata_i[0])
					s_d.prot_err = 1'b0;
				if (bus_bit_sel_i == STATUS_VFY_BIT && !bus_wdata_i[0])
					s_d.vfy_err = 1'b0;
			end
			else
			begin
				if (!bus_wdata_i[STATUS_PROT_BIT])
					s_d.prot_err = 1'b0;
				if (!bus_wdata_i[STATUS_VFY_BIT])
					s_d.vfy_err = 1'b0;
			end
		end
		if (prot_set)
			s_d.prot_err = 1'b1;
		if (vfy_set)
			s_d.vfy_err = 1'b1;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s_q.block_number_compare <= COMPARE_RESET;
			s_q.end_address_compare  <= COMPARE_RESET;
			s_q.program_data_buffer  <= BUFFER_RESET;
			s_q.state                <= ST_IDLE;
			s_q.op                   <= 3'h0;
			s_q.pulse                <= 1'b0;
			s_q.inc                  <= 1'b0;
			s_q.low_inc              <= 1'b0;
			s_q.prot_err             <= 1'b0;
			s_q.vfy_err              <= 1'b0;
			s_q.done                 <= 1'b0;
			s_q.rdata                <= 8'h00;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign bus_rdata_o                 = s_q.rdata;
	assign pointer_inc_o               = s_q.inc;
	assign pointer_low_inc_o           = s_q.low_inc;
	assign flash_pulse_o               = s_q.pulse;
	assign flash_op_o                  = s_q.op;
	assign program_data_o              = s_q.program_data_buffer;
	assign erase_write_protect_error_o = s_q.prot_err;
	assign verify_fail_flag_o          = s_q.vfy_err;
	assign busy_o                      = (s_q.state != ST_IDLE);
	assign done_o                      = s_q.done;
endmodule

// file: src/protect_decode.sv
// decodes the protect select code into a protected block limit
`timescale 1ns/100ps
module protect_decode
	import flash_range_pkg::*;
#(
	parameter int NUM_BLOCKS = 16
)
(
	input  wire logic [4:0]            select_i,
	input  wire logic [BLOCK_BITS-1:0] block_i,
	output logic                       protected_o,
	output logic                       prohibited_o
);
	logic [4:0] top_block;
	logic       valid;

	always_comb
	begin
		top_block = 5'h00;
		valid     = 1'b0;
		if (select_i == SELECT_NONE)
		begin
			valid = 1'b1;
		end
		else if (select_i[4:3] == 2'b01)
		begin
			// code 01xyz protects blocks up to 2*(7-xyz)+1
			top_block = 5'(({2'b00, ~select_i[2:0]} << 1) + 5'h01);
			valid     = (top_block < 5'(NUM_BLOCKS));
		end
	end

	assign prohibited_o = !valid;
	assign protected_o  = valid && (select_i != SELECT_NONE)
		&& ({1'b0, block_i} <= top_block);
endmodule

// file: test/flash_range_chk.sv
// assertions for the range compare, buffer and protect block
`timescale 1ns/100ps
module flash_range_chk
	import flash_range_pkg::*;
#(
	parameter int NUM_BLOCKS = 16
)
(
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic        bus_wr_i,
	input wire logic        bus_bit_i,
	input wire logic [7:0]  bus_wdata_i,
	input wire logic        selfprog_mode_i,
	input wire logic [7:0]  protect_byte_i,
	input wire logic [2:0]  flash_command_reg_i,
	input wire logic        start_i,
	input wire logic [7:0]  block_number_pointer_i,
	input wire logic        flash_pulse_o,
	input wire logic [2:0]  flash_op_o,
	input wire logic [7:0]  program_data_o,
	input wire logic        erase_write_protect_error_o,
	input wire logic        verify_fail_flag_o,
	input wire logic        busy_o
);
	import flash_range_pkg::*;
	// ============================================================
	// protected range of the select code
	logic [4:0] sel;
	logic [4:0] lim;
	logic       go;
	logic       prot;
	logic       buf_wr;
	logic       cmd_ok;
	assign sel = protect_byte_i[SELECT_MSB:SELECT_LSB];
	assign lim = 5'h0F - {1'b0, sel[2:0], 1'b0};
	assign go = start_i && selfprog_mode_i && !busy_o;
	assign prot = sel != SELECT_NONE && (sel[4:3] != 2'b01
		|| lim >= NUM_BLOCKS || block_number_pointer_i <= 8'(lim));
	assign buf_wr = bus_wr_i && bus_addr_i == PROGRAM_DATA_BUFFER_ADDR;
	assign cmd_ok = flash_command_reg_i == CMD_VERIFY
		|| flash_command_reg_i == CMD_ERASE
		|| flash_command_reg_i == CMD_BLANK
		|| flash_command_reg_i == CMD_WRITE;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// ============================================================
	// properties
	a_prot_err_set: assert property (go && prot |-> ##2
		erase_write_protect_error_o) else $error("protect error missing");
	a_prot_no_pulse: assert property (go && prot |=>
		!flash_pulse_o [*3]) else $error("pulse on protected block");
	a_free_pulse: assert property (go && !prot && cmd_ok |-> ##2
		flash_pulse_o) else $error("pulse missing");
	a_pulse_op: assert property (flash_pulse_o |->
		flash_op_o == flash_command_reg_i) else $error("wrong op code");
	a_mode_off_idle: assert property (!selfprog_mode_i && !busy_o |=>
		!busy_o) else $error("started outside mode");
	a_buf_byte: assert property (buf_wr && !bus_bit_i |=>
		program_data_o == $past(bus_wdata_i)) else $error("buffer write");
	a_buf_no_bit: assert property (buf_wr && bus_bit_i |=>
		$stable(program_data_o)) else $error("bit write to buffer");
	a_vfail_hold: assert property (verify_fail_flag_o && !(bus_wr_i
		&& bus_addr_i == FLASH_STATUS_ADDR) |=> verify_fail_flag_o)
		else $error("verify flag dropped");
	cover property (go && prot);
	cover property (go && !prot);
	cover property ($rose(verify_fail_flag_o));
endmodule

bind flash_selfprog_range_protect flash_range_chk #(
	.NUM_BLOCKS (NUM_BLOCKS)
) chk (
	.clk_i                       (clk_i),
	.reset_n_i                   (reset_n_i),
	.bus_addr_i                  (bus_addr_i),
	.bus_wr_i                    (bus_wr_i),
	.bus_bit_i                   (bus_bit_i),
	.bus_wdata_i                 (bus_wdata_i),
	.selfprog_mode_i             (selfprog_mode_i),
	.protect_byte_i              (protect_byte_i),
	.flash_command_reg_i         (flash_command_reg_i),
	.start_i                     (start_i),
	.block_number_pointer_i      (block_number_pointer_i),
	.flash_pulse_o               (flash_pulse_o),
	.flash_op_o                  (flash_op_o),
	.program_data_o              (program_data_o),
	.erase_write_protect_error_o (erase_write_protect_error_o),
	.verify_fail_flag_o          (verify_fail_flag_o),
	.busy_o                      (busy_o)
);

// file: test/tb.sv
// self-checking bench for the range compare, buffer and protect block
`timescale 1ns/100ps
module tb;
	import flash_range_pkg::*;
	logic clk_i = 0, reset_n_i = 0, bus_wr_i = 0, bus_bit_i = 0, start_i = 0;
	logic selfprog_mode_i = 0, flash_ready_i = 0, flash_verify_ok_i = 1;
	logic [15:0] bus_addr_i = 16'h0000;
	logic [7:0] bus_wdata_i = 8'h00, protect_byte_i = 8'hFF, bus_rdata_o;
	logic [7:0] block_number_pointer_i = 8'h00, low_address_pointer_i = 8'h00;
	logic [7:0] program_data_o;
	logic [2:0] bus_bit_sel_i = 3'h7, flash_command_reg_i = 3'h0, flash_op_o;
	logic pointer_inc_o, pointer_low_inc_o, flash_pulse_o, done_o, busy_o;
	logic erase_write_protect_error_o, verify_fail_flag_o;
	logic [7:0] low_start = 8'h00;
	int err_count = 0, comparisons = 0, incs = 0;
	flash_selfprog_range_protect DUT (
		.clk_i                       (clk_i),
		.reset_n_i                   (reset_n_i),
		.bus_addr_i                  (bus_addr_i),
		.bus_wr_i                    (bus_wr_i),
		.bus_bit_i                   (bus_bit_i),
		.bus_bit_sel_i               (bus_bit_sel_i),
		.bus_wdata_i                 (bus_wdata_i),
		.bus_rdata_o                 (bus_rdata_o),
		.selfprog_mode_i             (selfprog_mode_i),
		.protect_byte_i              (protect_byte_i),
		.flash_command_reg_i         (flash_command_reg_i),
		.start_i                     (start_i),
		.block_number_pointer_i      (block_number_pointer_i),
		.low_address_pointer_i       (low_address_pointer_i),
		.pointer_inc_o               (pointer_inc_o),
		.pointer_low_inc_o           (pointer_low_inc_o),
		.flash_pulse_o               (flash_pulse_o),
		.flash_op_o                  (flash_op_o),
		.program_data_o              (program_data_o),
		.flash_ready_i               (flash_ready_i),
		.flash_verify_ok_i           (flash_verify_ok_i),
		.erase_write_protect_error_o (erase_write_protect_error_o),
		.verify_fail_flag_o          (verify_fail_flag_o),
		.busy_o                      (busy_o),
		.done_o                      (done_o)
	);
	always #25 clk_i = ~clk_i;
	// ============================================================
	// shared tasks
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("errors %0d compares %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d, input logic b);
		@(negedge clk_i);
		bus_addr_i = a;
		bus_wdata_i = d;
		bus_bit_i = b;
		bus_wr_i = 1;
		@(negedge clk_i);
		bus_wr_i = 0;
	endtask
	task rdc(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk_i);
		bus_addr_i = a;
		@(negedge clk_i);
		chk(bus_rdata_o, e);
	endtask
	task run(input logic [2:0] c, input logic [7:0] b, e, output int n);
		flash_command_reg_i = c;
		block_number_pointer_i = {4'h0, b[3:0]};
		low_address_pointer_i = low_start;
		wr(BLOCK_NUMBER_COMPARE_ADDR, {4'h0, b[3:0]}, 0);
		wr(END_ADDRESS_COMPARE_ADDR, e, 0);
		wr(FLASH_STATUS_ADDR, 8'h00, 0);
		start_i = 1;
		@(negedge clk_i);
		start_i = 0;
		n = 0;
		incs = 0;
		for (int i = 0; !done_o; i++)
		begin
			if (i == 1000)
			begin
				err_count++;
				finish_test;
			end
			@(negedge clk_i);
			n += int'(flash_pulse_o);
			incs += int'(pointer_inc_o);
			flash_ready_i = flash_pulse_o;
			low_address_pointer_i += 8'(pointer_low_inc_o);
		end
		flash_ready_i = 0;
	endtask
	// ============================================================
	// scenarios
	task s_regs;
		rdc(BLOCK_NUMBER_COMPARE_ADDR, 8'h00);
		rdc(END_ADDRESS_COMPARE_ADDR, 8'h00);
		rdc(PROGRAM_DATA_BUFFER_ADDR, 8'h00);
		rdc(16'hFFA9, 8'h00);
		wr(BLOCK_NUMBER_COMPARE_ADDR, 8'h0A, 0);
		rdc(BLOCK_NUMBER_COMPARE_ADDR, 8'h0A);
		wr(END_ADDRESS_COMPARE_ADDR, 8'h01, 1);
		rdc(END_ADDRESS_COMPARE_ADDR, 8'h80);
		wr(PROGRAM_DATA_BUFFER_ADDR, 8'hC3, 0);
		wr(PROGRAM_DATA_BUFFER_ADDR, 8'h00, 1);
		rdc(PROGRAM_DATA_BUFFER_ADDR, 8'hC3);
		chk(program_data_o, 8'hC3);
	endtask
	task s_mode_off;
		start_i = 1;
		@(negedge clk_i);
		start_i = 0;
		repeat (3) @(negedge clk_i);
		chk(8'(busy_o), 8'h00);
	endtask
	task s_prot(input logic [2:0] c, input logic [4:0] s,
		input logic [7:0] b, input logic e);
		int n;
		protect_byte_i = {1'b1, s, 2'b11};
		run(c, b, 8'h00, n);
		chk(8'(erase_write_protect_error_o), 8'(e));
		chk(8'(n), e ? 8'h00 : 8'h01);
	endtask
	task s_verify;
		int n;
		protect_byte_i = 8'hFF;
		run(CMD_VERIFY, 8'h02, 8'h03, n);
		chk(8'(n), 8'h04);
		chk(8'(verify_fail_flag_o), 8'h00);
		run(CMD_BLANK, 8'h02, 8'hFF, n);
		chk(8'(n >> 8), 8'h01);
		chk(8'(n), 8'h00);
		low_start = 8'hFF;
		run(CMD_VERIFY, 8'h02, 8'h00, n);
		chk(8'(n), 8'h02);
		chk(8'(incs), 8'h01);
		low_start = 8'h00;
		flash_verify_ok_i = 0;
		run(CMD_VERIFY, 8'h02, 8'h03, n);
		chk(8'(n), 8'h01);
		chk(8'(verify_fail_flag_o), 8'h01);
		flash_verify_ok_i = 1;
	endtask
	task s_reset;
		@(negedge clk_i);
		reset_n_i = 0;
		@(negedge clk_i);
		reset_n_i = 1;
		chk(program_data_o, 8'h00);
		rdc(BLOCK_NUMBER_COMPARE_ADDR, 8'h00);
		rdc(END_ADDRESS_COMPARE_ADDR, 8'h00);
	endtask
	initial
	begin
		repeat (2) @(negedge clk_i);
		reset_n_i = 1;
		s_regs;
		s_reset;
		s_mode_off;
		selfprog_mode_i = 1;
		s_prot(CMD_ERASE, 5'h08, 8'h0F, 1);
		s_prot(CMD_WRITE, 5'h0F, 8'h01, 1);
		s_prot(CMD_WRITE, 5'h0F, 8'h02, 0);
		s_prot(CMD_ERASE, 5'h0C, 8'h07, 1);
		s_prot(CMD_ERASE, 5'h0C, 8'h08, 0);
		s_prot(CMD_ERASE, 5'h0E, 8'h03, 1);
		s_prot(CMD_ERASE, 5'h1F, 8'h00, 0);
		s_prot(CMD_ERASE, 5'h10, 8'h05, 1);
		s_verify;
		finish_test;
	end
endmodule
